//--- hw/sel_err_counter.sv
`timescale 1ns/1ps
`default_nettype none
// link error counter, pixel clock enable domain
module sel_err_counter
	import sel_pkg::*;
(
	input  wire logic       clock,      // system clock
	input  wire logic       rst,        // sync reset, high
	input  wire logic       pixEn,      // pixel clock enable
	input  wire logic [2:0] linkErr,    // clk0, clk1, data channel errors
	input  wire logic       countEn,    // counting enabled
	input  wire logic [3:0] threshold,  // error threshold
	input  wire logic       lockIn,     // lock from lock detector
	output logic            lockDrop,   // force loss of lock
	output logic [3:0]      errCount    // current count
);
	typedef struct packed {
		logic [3:0] cnt;
		logic       drop;
		logic       lockPrev;
	} sel_cnt_t;
	sel_cnt_t s_r, s_nxt;
	logic hit;

	// ==========================================================
	// counting
	always_comb begin
		s_nxt = s_r;
		// (RL14) any channel error
		hit = |linkErr;
		if (pixEn) begin
			s_nxt.lockPrev = lockIn;
			// (RL19) fresh count on new lock
			if (!countEn || (lockIn && !s_r.lockPrev)) begin
				s_nxt.cnt  = 4'h0;
				s_nxt.drop = 1'b0;
			end
			if (hit) begin
				// (RL16) one error drops lock when counting disabled
				if (!countEn) begin
					s_nxt.drop = 1'b1;
				end else if (s_nxt.cnt != 4'hF) begin
					s_nxt.cnt = s_nxt.cnt + 4'h1;
				end
			end
			// (RL15) reaching threshold drops lock
			if (countEn && (s_nxt.cnt >= threshold) && (s_nxt.cnt != 4'h0 || hit)) begin
				s_nxt.drop = 1'b1;
			end
		end
	end

	// (RL13) pixel clock based counter
	always_ff @(posedge clock) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign lockDrop = s_r.drop;
	assign errCount = s_r.cnt;

	// (RL16) single error when disabled
	chk_drop_first: assert property (@(posedge clock) disable iff (rst) // (RL16)
		pixEn && !countEn && (|linkErr) |=> lockDrop)
		else $error("lock not dropped on first error");
	// (RL15) threshold reached
	chk_drop_thresh: assert property (@(posedge clock) disable iff (rst) // (RL15)
		pixEn && countEn && $past(countEn) && (|linkErr) && (errCount + 4'h1 == threshold)
		&& !(lockIn && !s_r.lockPrev) |=> lockDrop)
		else $error("lock not dropped at threshold");
endmodule
`default_nettype wire

//--- hw/sel_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// (RL1) backchannel strap latched flag bit 7
// (RL2) backchannel strap code bits 6:4 rate/medium
// (RL3) output format strap latched flag bit 3
// (RL4) output format code bits 2:0, low two
// (RL5) out divider override gates software field
// (RL6) out divider code to divide ratio
// (RL7) in divider override versus state machine
// (RL8) in divider code to divide ratio
// (RL9) bypass returns stage values from bypass reg
// (RL10) adaptive mode returns engine setting
// (RL11) second port select returns port two status
// (RL12) error count enable bit 4, reset 0
// (RL13) threshold bits 3:0 reset 3, pixel clock
// (RL14) both clocks and data channel monitored
// (RL15) drop lock at threshold when enabled
// (RL16) drop lock on first error when disabled
// (RL17) port select steers, writes hit shared
// (RL18) stage one bits 2:0, two bits 5:3
// (RL19) counter clears on new lock or disable
module sel_regs
	import sel_pkg::*;
(
	input  wire logic       clock,        // system clock 250 MHz
	input  wire logic       rst,          // sync reset, high
	input  wire logic [7:0] regAddr,      // control bus address
	input  wire logic [7:0] regWdata,     // write data
	input  wire logic       regWr,        // write strobe
	input  wire logic       regRd,        // read strobe
	output logic [7:0]      regRdata,     // read data, registered
	input  wire logic [2:0] bcStrapPin,   // backchannel strap decode from sampler
	input  wire logic       bcStrapDone,  // backchannel decode complete
	input  wire logic [2:0] fmtStrapPin,  // format strap decode from sampler
	input  wire logic       fmtStrapDone, // format decode complete
	output logic            bcHighRate,   // 1: 20 Mbps, 0: 5 Mbps
	output logic            bcCoax,       // 1: coax, 0: twisted pair
	output logic [1:0]      outFormat,    // 00 dual,01 swap,10 single,11 repl
	input  wire logic [1:0] pllSmInDiv,   // state machine input divide code
	output logic [5:0]      outDivRatio,  // output divide ratio, 0: no override
	output logic [3:0]      inDivRatio,   // input divide ratio
	input  wire logic [5:0] aeqSetting0,  // adaptive engine setting port 1
	input  wire logic [5:0] aeqSetting1,  // adaptive engine setting port 2
	output logic [5:0]      eqDrive0,     // equalizer setting to analog port 1
	output logic [5:0]      eqDrive1,     // equalizer setting to analog port 2
	input  wire logic       pixEn,        // pixel clock enable
	input  wire logic [2:0] linkErr,      // clk0, clk1, data channel errors
	input  wire logic       lockIn,       // lock from lock detector
	output logic            lockDrop      // force loss of lock
);
	typedef struct packed {
		logic [2:0] bcCode;
		logic       bcDone;
		logic [2:0] fmtCode;
		logic       fmtDone;
		logic [7:0] adiv;
		logic [4:0] lerr;
		logic [7:0] dualRx;
		logic [7:0] eqByp0;
		logic [7:0] eqByp1;
		logic [7:0] rdata;
	} sel_regs_t;
	sel_regs_t s_r, s_nxt;
	logic [3:0] errCount;
	logic [2:0] bcSync1_r, bcSync2_r, fmtSync1_r, fmtSync2_r;
	logic [1:0] doneSync1_r, doneSync2_r;
	logic [1:0] inCode;
	logic       port2;

	// ==========================================================
	// equalizer status decode, used for both ports
	// (RL18) stage one low, stage two high
	function automatic logic [5:0] eqStatus(input logic [7:0] byp, input logic [5:0] aeq);
		// (RL9) bypass uses programmed stages
		if (byp[EQBYP_DIS_BIT]) begin
			eqStatus = {byp[EQBYP_ST2_LSB +: 3], byp[EQBYP_ST1_LSB +: 3]};
		end else begin
			// (RL10) engine setting when adapting
			eqStatus = aeq;
		end
	endfunction

	// ==========================================================
	// strap inputs come from pins: two-flop synchronisers
	always_ff @(posedge clock) begin
		bcSync1_r   <= bcStrapPin;
		bcSync2_r   <= bcSync1_r;
		fmtSync1_r  <= fmtStrapPin;
		fmtSync2_r  <= fmtSync1_r;
		doneSync1_r <= {bcStrapDone, fmtStrapDone};
		doneSync2_r <= doneSync1_r;
	end

	assign port2 = s_r.dualRx[PORT2_SEL_BIT];

	// ==========================================================
	// register updates
	always_comb begin
		s_nxt = s_r;
		// (RL1) capture once, then flag stays
		if (doneSync2_r[1] && !s_r.bcDone) begin
			s_nxt.bcCode = bcSync2_r;
			s_nxt.bcDone = 1'b1;
		end
		// (RL3) capture once, then flag stays
		if (doneSync2_r[0] && !s_r.fmtDone) begin
			s_nxt.fmtCode = fmtSync2_r;
			s_nxt.fmtDone = 1'b1;
		end
		if (regWr) begin
			if (regAddr == ADDR_ADIV) begin
				s_nxt.adiv = regWdata & ADIV_WMASK;
			end else if (regAddr == ADDR_LERR) begin
				// (RL12) enable bit and threshold
				s_nxt.lerr = regWdata[4:0];
			end else if (regAddr == ADDR_DUALRX) begin
				s_nxt.dualRx = regWdata & DUALRX_WMASK;
			end else if (regAddr == ADDR_EQBYP) begin
				// (RL17) port select steers the write
				if (port2) begin
					s_nxt.eqByp1 = regWdata & EQBYP_WMASK;
				end else begin
					s_nxt.eqByp0 = regWdata & EQBYP_WMASK;
				end
			end
		end
		if (regRd) begin
			if (regAddr == ADDR_STRAP) begin
				s_nxt.rdata = {s_r.bcDone, s_r.bcCode, s_r.fmtDone, s_r.fmtCode};
			end else if (regAddr == ADDR_ADIV) begin
				s_nxt.rdata = s_r.adiv;
			end else if (regAddr == ADDR_EQSTAT) begin
				// (RL11) second port status when selected
				s_nxt.rdata = {2'b00, port2 ? eqStatus(s_r.eqByp1, aeqSetting1)
				                            : eqStatus(s_r.eqByp0, aeqSetting0)};
			end else if (regAddr == ADDR_LERR) begin
				s_nxt.rdata = {3'b000, s_r.lerr};
			end else if (regAddr == ADDR_DUALRX) begin
				s_nxt.rdata = s_r.dualRx;
			end else if (regAddr == ADDR_EQBYP) begin
				s_nxt.rdata = port2 ? s_r.eqByp1 : s_r.eqByp0;
			end else begin
				s_nxt.rdata = 8'h00;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			s_r        <= '0;
			s_r.adiv   <= RST_ADIV;
			s_r.lerr   <= {1'b0, RST_THRESH};
			s_r.dualRx <= RST_DUALRX;
			s_r.eqByp0 <= RST_EQBYP;
			s_r.eqByp1 <= RST_EQBYP;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// decoded outputs
	// (RL2) rate from bit 5, medium from bit 4
	assign bcHighRate = s_r.bcCode[1];
	assign bcCoax     = s_r.bcCode[0];
	// (RL4) bit 2 ignored for format
	assign outFormat  = s_r.fmtCode[1:0];
	assign regRdata   = s_r.rdata;
	assign eqDrive0   = eqStatus(s_r.eqByp0, aeqSetting0);
	assign eqDrive1   = eqStatus(s_r.eqByp1, aeqSetting1);

	// output divider ratio, zero means the pll keeps its own choice
	always_comb begin
		// (RL5) override gates the field
		if (!s_r.adiv[ADIV_OUT_OVR_BIT]) begin
			outDivRatio = 6'd0;
		end else begin
			// (RL6) code to ratio
			case (s_r.adiv[ADIV_OUT_LSB +: 3])
				3'b000:  outDivRatio = 6'd32;
				3'b001:  outDivRatio = 6'd16;
				3'b010:  outDivRatio = 6'd8;
				3'b011:  outDivRatio = 6'd4;
				3'b100,
				3'b101:  outDivRatio = 6'd2;
				default: outDivRatio = 6'd1;
			endcase
		end
	end

	// (RL7) software or state machine code
	assign inCode = s_r.adiv[ADIV_IN_OVR_BIT] ? s_r.adiv[ADIV_IN_LSB +: 2] : pllSmInDiv;
	// (RL8) 1,2,4,8
	assign inDivRatio = 4'h1 << inCode;

	// ==========================================================
	// link error monitor
	sel_err_counter u_cnt (
		.clock     (clock),
		.rst       (rst),
		.pixEn     (pixEn),
		.linkErr   (linkErr),
		.countEn   (s_r.lerr[LERR_EN_BIT]),
		.threshold (s_r.lerr[3:0]),
		.lockIn    (lockIn),
		.lockDrop  (lockDrop),
		.errCount  (errCount)
	);

	// (RL1) flag only after a capture
	chk_bc_done: assert property (@(posedge clock) disable iff (rst) // (RL1)
		!s_r.bcDone && !doneSync2_r[1] |=> !s_r.bcDone)
		else $error("backchannel flag set without capture");
	// (RL3) format flag set within a cycle
	chk_fmt_done: assert property (@(posedge clock) disable iff (rst) // (RL3)
		doneSync2_r[0] |=> s_r.fmtDone)
		else $error("format flag not set");
	// (RL5) no override gives zero
	chk_out_ovr: assert property (@(posedge clock) disable iff (rst) // (RL5)
		!s_r.adiv[ADIV_OUT_OVR_BIT] |-> outDivRatio == 6'd0)
		else $error("output divider used without override");
	// (RL7) state machine code when not overridden
	chk_in_ovr: assert property (@(posedge clock) disable iff (rst) // (RL7)
		!s_r.adiv[ADIV_IN_OVR_BIT] && pllSmInDiv == 2'b11 |-> inDivRatio == 4'h8)
		else $error("input divider not from state machine");
	// (RL11) second port status read
	chk_eq_port2: assert property (@(posedge clock) disable iff (rst) // (RL11)
		regRd && regAddr == ADDR_EQSTAT && port2 && !s_r.eqByp1[0]
		|=> regRdata == {2'b00, $past(aeqSetting1)})
		else $error("second port status not returned");
	// (RL12) enable written
	chk_lerr_wr: assert property (@(posedge clock) disable iff (rst) // (RL12)
		regWr && regAddr == ADDR_LERR |=> s_r.lerr == $past(regWdata[4:0]))
		else $error("error control not written");
	// (RL18) bypass stage placement
	chk_eq_byp: assert property (@(posedge clock) disable iff (rst) // (RL18)
		s_r.eqByp0[0] |-> eqDrive0[2:0] == s_r.eqByp0[7:5])
		else $error("stage one misplaced");
	// (RL2) rate from captured code
	chk_bc_rate: assert property (@(posedge clock) disable iff (rst) // (RL2)
		!s_r.bcDone && doneSync2_r[1] |=> bcHighRate == $past(bcSync2_r[1]))
		else $error("rate decode wrong");
	// (RL2) medium from captured code
	chk_bc_coax: assert property (@(posedge clock) disable iff (rst) // (RL2)
		!s_r.bcDone && doneSync2_r[1] |=> bcCoax == $past(bcSync2_r[0]))
		else $error("medium decode wrong");

	// ==========================================================
	// capture, divider, equalizer and steering checks
	// (RL1) backchannel capture holds
	chk_bc_hold: assert property (@(posedge clock) disable iff (rst) // (RL1)
		s_r.bcDone |=> s_r.bcDone && $stable(s_r.bcCode))
		else $error("backchannel capture changed");
	// (RL3) format capture holds
	chk_fmt_hold: assert property (@(posedge clock) disable iff (rst) // (RL3)
		s_r.fmtDone |=> s_r.fmtDone && $stable(s_r.fmtCode))
		else $error("format capture changed");
	// (RL4) format from low two bits
	chk_fmt_code: assert property (@(posedge clock) disable iff (rst) // (RL4)
		!s_r.fmtDone && doneSync2_r[0] |=> outFormat == $past(fmtSync2_r[1:0]))
		else $error("format decode wrong");
	// (RL1) done flags read back
	chk_strap_rd: assert property (@(posedge clock) disable iff (rst) // (RL1)
		regRd && regAddr == ADDR_STRAP
		|=> regRdata[7] == $past(s_r.bcDone) && regRdata[3] == $past(s_r.fmtDone))
		else $error("strap done flags misplaced");
	// (RL6) slowest output ratio
	chk_out_div32: assert property (@(posedge clock) disable iff (rst) // (RL6)
		s_r.adiv[ADIV_OUT_OVR_BIT] && s_r.adiv[ADIV_OUT_LSB +: 3] == 3'b000
		|-> outDivRatio == 6'd32)
		else $error("output divide by 32 wrong");
	// (RL6) fastest output ratio
	chk_out_div1: assert property (@(posedge clock) disable iff (rst) // (RL6)
		s_r.adiv[ADIV_OUT_OVR_BIT] && s_r.adiv[ADIV_OUT_LSB +: 3] == 3'b110
		|-> outDivRatio == 6'd1)
		else $error("output divide by 1 wrong");
	// (RL8) software input ratio
	chk_in_sw: assert property (@(posedge clock) disable iff (rst) // (RL8)
		s_r.adiv[ADIV_IN_OVR_BIT] && s_r.adiv[ADIV_IN_LSB +: 2] == 2'b10 |-> inDivRatio == 4'h4)
		else $error("input divide by 4 wrong");
	// (RL10) engine setting passes through
	chk_eq_adapt: assert property (@(posedge clock) disable iff (rst) // (RL10)
		!s_r.eqByp0[EQBYP_DIS_BIT] |-> eqDrive0 == aeqSetting0)
		else $error("engine setting not used");
	// (RL9) bypass stage one on port two
	chk_eq_bypass: assert property (@(posedge clock) disable iff (rst) // (RL9)
		s_r.eqByp1[EQBYP_DIS_BIT] |-> eqDrive1[2:0] == s_r.eqByp1[7:5])
		else $error("bypass stage one not used");
	// (RL18) stage two in high bits
	chk_eq_stage2: assert property (@(posedge clock) disable iff (rst) // (RL18)
		s_r.eqByp1[EQBYP_DIS_BIT] |-> eqDrive1[5:3] == s_r.eqByp1[3:1])
		else $error("stage two misplaced");
	// (RL11) first port status read
	chk_eq_port1: assert property (@(posedge clock) disable iff (rst) // (RL11)
		regRd && regAddr == ADDR_EQSTAT && !port2 |=> regRdata == {2'b00, $past(eqDrive0)})
		else $error("first port status not returned");
	// (RL17) shared register always written
	chk_wr_shared: assert property (@(posedge clock) disable iff (rst) // (RL17)
		regWr && regAddr == ADDR_ADIV |=> s_r.adiv == ($past(regWdata) & ADIV_WMASK))
		else $error("shared register not written");
	// (RL17) steered write spares port one
	chk_byp_steer: assert property (@(posedge clock) disable iff (rst) // (RL17)
		regWr && regAddr == ADDR_EQBYP && port2 |=> $stable(s_r.eqByp0))
		else $error("port one bypass changed");
endmodule
`default_nettype wire

//--- include/sel_pkg.sv
`default_nettype none
package sel_pkg;
	// ==========================================================
	// register offsets (8-bit control-bus address)
	localparam logic [7:0] ADDR_STRAP  = 8'h37;
	localparam logic [7:0] ADDR_ADIV   = 8'h3A;
	localparam logic [7:0] ADDR_EQSTAT = 8'h3B;
	localparam logic [7:0] ADDR_LERR   = 8'h41;
	localparam logic [7:0] ADDR_DUALRX = 8'h34;
	localparam logic [7:0] ADDR_EQBYP  = 8'h44;
	// ==========================================================
	// reset values
	localparam logic [7:0] RST_ADIV    = 8'h00;
	localparam logic [3:0] RST_THRESH  = 4'h3;
	localparam logic [7:0] RST_DUALRX  = 8'h01;
	localparam logic [7:0] RST_EQBYP   = 8'h60;
	// ==========================================================
	// field positions
	localparam int ADIV_OUT_OVR_BIT = 7;
	localparam int ADIV_OUT_LSB     = 4;
	localparam int ADIV_IN_OVR_BIT  = 2;
	localparam int ADIV_IN_LSB      = 0;
	localparam int LERR_EN_BIT      = 4;
	localparam int PORT2_SEL_BIT    = 1;
	localparam int EQBYP_DIS_BIT    = 0;
	localparam int EQBYP_ST1_LSB    = 5;
	localparam int EQBYP_ST2_LSB    = 1;
	// write mask of the writable registers
	localparam logic [7:0] ADIV_WMASK   = 8'hF7;
	localparam logic [7:0] LERR_WMASK   = 8'h1F;
	localparam logic [7:0] DUALRX_WMASK = 8'h7B;
	localparam logic [7:0] EQBYP_WMASK  = 8'hEF;
endpackage
`default_nettype wire

//--- testbench/test_strap_eq_link_error_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_strap_eq_link_error_regs
	import sel_pkg::*;
;
	// ==========================================================
	// stimulus and observed signals
	logic       clock, rst, regWr, regRd, bcStrapDone, fmtStrapDone, pixEn, lockIn;
	logic       bcHighRate, bcCoax, lockDrop;
	logic [7:0] regAddr, regWdata, regRdata;
	logic [2:0] bcStrapPin, fmtStrapPin, linkErr;
	logic [1:0] outFormat, pllSmInDiv;
	logic [5:0] outDivRatio, aeqSetting0, aeqSetting1, eqDrive0, eqDrive1;
	logic [3:0] inDivRatio;
	int         miscompares, check_count;

	sel_regs dut_u (.clock(clock), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .bcStrapPin(bcStrapPin),
		.bcStrapDone(bcStrapDone), .fmtStrapPin(fmtStrapPin), .fmtStrapDone(fmtStrapDone),
		.bcHighRate(bcHighRate), .bcCoax(bcCoax), .outFormat(outFormat),
		.pllSmInDiv(pllSmInDiv), .outDivRatio(outDivRatio), .inDivRatio(inDivRatio),
		.aeqSetting0(aeqSetting0), .aeqSetting1(aeqSetting1), .eqDrive0(eqDrive0),
		.eqDrive1(eqDrive1), .pixEn(pixEn), .linkErr(linkErr), .lockIn(lockIn),
		.lockDrop(lockDrop));

	// 250 MHz clock
	always #2 clock = ~clock;

	// ==========================================================
	// shared tasks
	task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		regAddr  <= a;
		regWdata <= d;
		regWr    <= 1'b1;
		@(posedge clock);
		regWr <= 1'b0;
	endtask

	// read data is registered, so look just after the edge that takes the strobe
	task rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge clock);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge clock);
		regRd <= 1'b0;
		#1;
		chk(regRdata, exp, what);
	endtask

	task settle;
		@(posedge clock);
		#1;
	endtask

	// one pixel-enable pulse carrying the given channel errors
	task pix(input logic [2:0] e);
		@(posedge clock);
		pixEn   <= 1'b1;
		linkErr <= e;
		@(posedge clock);
		pixEn   <= 1'b0;
		linkErr <= 3'b000;
		settle;
	endtask

	// ==========================================================
	// scenarios
	task test_reset;
		rd(ADDR_STRAP, 8'h00, "strap rst");
		rd(ADDR_ADIV, 8'h00, "adiv rst");
		rd(ADDR_LERR, 8'h03, "lerr rst");
		rd(ADDR_EQSTAT, 8'h2A, "eq rst");
		rd(8'h50, 8'h00, "unmapped");
		chk({7'b0, lockDrop}, 8'h00, "drop rst");
	endtask

	task test_straps;
		@(posedge clock);
		bcStrapPin   <= 3'b110;
		fmtStrapPin  <= 3'b011;
		bcStrapDone  <= 1'b1;
		fmtStrapDone <= 1'b1;
		repeat (6) settle;
		rd(ADDR_STRAP, 8'hEB, "strap val");
		chk({5'b0, bcHighRate, bcCoax, outFormat}, 8'h0B, "strap dec");
		@(posedge clock);
		bcStrapPin  <= 3'b001;
		fmtStrapPin <= 3'b100;
		wr(ADDR_STRAP, 8'h00);
		repeat (4) settle;
		rd(ADDR_STRAP, 8'hEB, "strap hold");
	endtask

	task test_divider;
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_ADIV, {1'b1, i[2:0], 2'b01, i[1:0]});
			settle;
			chk({2'b0, outDivRatio}, (i >= 6) ? 8'd1 : (i >= 4) ? 8'd2 : (8'd32 >> i), "odiv");
			chk({4'b0, inDivRatio}, 8'd1 << i[1:0], "idiv");
		end
		@(posedge clock);
		pllSmInDiv <= 2'b11;
		wr(ADDR_ADIV, 8'h70);
		settle;
		chk({2'b0, outDivRatio}, 8'h00, "odiv off");
		chk({4'b0, inDivRatio}, 8'h08, "idiv sm");
		wr(ADDR_ADIV, 8'hFF);
		rd(ADDR_ADIV, 8'hF7, "adiv rb");
	endtask

	task test_equalizer;
		wr(ADDR_EQBYP, 8'hA5);
		rd(ADDR_EQSTAT, 8'h15, "eq byp0");
		chk({2'b0, eqDrive0}, 8'h15, "drive0");
		wr(ADDR_DUALRX, 8'h02);
		rd(ADDR_EQSTAT, 8'h11, "eq port2");
		wr(ADDR_EQBYP, 8'h0D);
		rd(ADDR_EQSTAT, 8'h30, "eq byp1");
		chk({2'b0, eqDrive1}, 8'h30, "drive1");
		chk({2'b0, eqDrive0}, 8'h15, "drive0 kept");
		rd(ADDR_EQBYP, 8'h0D, "byp rb");
		wr(ADDR_DUALRX, 8'h01);
		rd(ADDR_EQSTAT, 8'h15, "eq back0");
		wr(ADDR_EQBYP, 8'hA4);
		wr(ADDR_EQSTAT, 8'hFF);
		rd(ADDR_EQSTAT, 8'h2A, "eq adapt");
	endtask

	task test_errors;
		@(posedge clock);
		lockIn <= 1'b1;
		wr(ADDR_LERR, 8'h12);
		rd(ADDR_LERR, 8'h12, "lerr rb");
		pix(3'b001);
		chk({7'b0, lockDrop}, 8'h00, "one err");
		@(posedge clock);
		linkErr <= 3'b010;
		@(posedge clock);
		linkErr <= 3'b000;
		pix(3'b000);
		chk({7'b0, lockDrop}, 8'h00, "no pix");
		pix(3'b100);
		chk({7'b0, lockDrop}, 8'h01, "at thr");
		repeat (3) settle;
		chk({7'b0, lockDrop}, 8'h01, "drop holds");
		// lock is only seen on pixel enables, so each level needs one
		@(posedge clock);
		lockIn <= 1'b0;
		pix(3'b000);
		chk({7'b0, lockDrop}, 8'h01, "lock low");
		@(posedge clock);
		lockIn <= 1'b1;
		pix(3'b000);
		chk({7'b0, lockDrop}, 8'h00, "relock");
		pix(3'b010);
		chk({7'b0, lockDrop}, 8'h00, "fresh cnt");
		pix(3'b001);
		chk({7'b0, lockDrop}, 8'h01, "thr again");
		wr(ADDR_LERR, 8'h02);
		pix(3'b000);
		chk({7'b0, lockDrop}, 8'h00, "disabled");
		pix(3'b010);
		chk({7'b0, lockDrop}, 8'h01, "first err");
	endtask

	task conclude;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		clock = 0; rst = 1; regWr = 0; regRd = 0; regAddr = 0; regWdata = 0;
		bcStrapPin = 0; bcStrapDone = 0; fmtStrapPin = 0; fmtStrapDone = 0;
		pllSmInDiv = 0; aeqSetting0 = 6'h2A; aeqSetting1 = 6'h11;
		pixEn = 0; linkErr = 0; lockIn = 0; miscompares = 0; check_count = 0;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		test_reset;
		test_straps;
		test_divider;
		test_equalizer;
		test_errors;
		conclude;
	end

	// watchdog: the whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clock);
		miscompares++;
		conclude;
	end
endmodule
`default_nettype wire
